// File: rtl/uip_err_if.sv
// Receive FIFO error bookkeeping signals between top and tracker
`timescale 1ns/1ps
`default_nettype none
interface uip_err_if;
    logic push;
    logic push_err;
    logic pop;
    logic pop_err;
    logic fifo_err;
    modport tracker (input push, input push_err, input pop, input pop_err, output fifo_err);
    modport owner   (output push, output push_err, output pop, output pop_err, input fifo_err);
endinterface
`default_nettype wire

// File: rtl/uip_err_track.sv
// Count of erroneous characters held in the receive FIFO
`timescale 1ns/1ps
`default_nettype none
module uip_err_track #(
    parameter int DEPTH = 64
) (
    input  wire logic  clk,   // Device clock
    input  wire logic  srst,  // Synchronous reset
    uip_err_if.tracker eb     // Push/pop error events and aggregate flag
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [CW-1:0] errcnt_ff;
    logic          inc;
    logic          dec;

    assign inc = eb.push & eb.push_err;
    assign dec = eb.pop & eb.pop_err & (errcnt_ff != '0);

    always_ff @(posedge clk) begin
        if (srst) begin
            errcnt_ff <= '0;
        end else if (inc & ~dec) begin
            errcnt_ff <= errcnt_ff + CW'(1);
        end else if (dec & ~inc) begin
            errcnt_ff <= errcnt_ff - CW'(1);
        end
    end

    assign eb.fifo_err = (errcnt_ff != '0);

    err_set_a: assert property (@(posedge clk) disable iff (srst)
        inc && !dec |=> eb.fifo_err)
        else $error("aggregate error flag not set after erroneous push");
    err_last_a: assert property (@(posedge clk) disable iff (srst)
        errcnt_ff == CW'(1) && dec && !inc |=> !eb.fifo_err)
        else $error("aggregate error flag not cleared after last error popped");
endmodule
`default_nettype wire

// File: rtl/uip_map.svh
// Register offsets, field positions, codes and reset values of the interrupt prioritizer
`ifndef UIP_MAP_SVH
`define UIP_MAP_SVH

`define UIP_OFF_IER    8'h00
`define UIP_OFF_IDENT  8'h04
`define UIP_OFF_LSR    8'h08
`define UIP_OFF_MSR    8'h0c
`define UIP_OFF_RHR    8'h10
`define UIP_OFF_THR    8'h14
`define UIP_OFF_FCTL   8'h18
`define UIP_OFF_ISTS   8'h1c
`define UIP_OFF_IMSK   8'h20

`define UIP_IE_RX      0
`define UIP_IE_TX      1
`define UIP_IE_LS      2
`define UIP_IE_MS      3
`define UIP_IE_XOFF    4
`define UIP_IE_FLOW    5
`define UIP_IE_W       6

`define UIP_LS_DR      0
`define UIP_LS_OE      1
`define UIP_LS_HEAD    2
`define UIP_LS_THE     5
`define UIP_LS_FERR    7

`define UIP_FC_EN      0
`define UIP_FC_RXT     8
`define UIP_FC_TXT     16
`define UIP_TRIG_RST   8'h08

`define UIP_NSRC       7
`define UIP_S_LS       0
`define UIP_S_TO       1
`define UIP_S_RXD      2
`define UIP_S_TX       3
`define UIP_S_MS       4
`define UIP_S_XOFF     5
`define UIP_S_FLOW     6

`define UIP_ID_NONE    6'h01
`define UIP_ID_LS      6'h06
`define UIP_ID_TO      6'h0c
`define UIP_ID_RXD     6'h04
`define UIP_ID_TX      6'h02
`define UIP_ID_MS      6'h00
`define UIP_ID_XOFF    6'h10
`define UIP_ID_FLOW    6'h20

`endif

// File: rtl/uip_pkg.sv
// Types shared by the interrupt prioritizer modules
package uip_pkg;
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_LS,
        SRC_TO,
        SRC_RXD,
        SRC_TX,
        SRC_MS,
        SRC_XOFF,
        SRC_FLOW
    } uip_src_t;
endpackage

// File: rtl/uip_top.sv
// Interrupt source, priority and clearing logic for one serial channel
`timescale 1ns/1ps
`default_nettype none
`include "uip_map.svh"

module uip_top #(
    parameter int DEPTH = 64,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic          clk,          // Device clock, 20 MHz
    input  wire logic          srst,         // Synchronous reset, active high
    input  wire logic          psel,         // APB select
    input  wire logic          penable,      // APB enable
    input  wire logic          pwrite,       // APB direction
    input  wire logic [7:0]    paddr,        // APB byte address
    input  wire logic [31:0]   pwdata,       // APB write data
    output logic      [31:0]   prdata,       // APB read data
    output logic               pready,       // APB ready
    output logic               pslverr,      // APB error on unmapped address
    input  wire logic [CW-1:0] rx_count,     // Receive FIFO fill level
    input  wire logic [7:0]    rx_head_data, // Character at receive FIFO head
    input  wire logic [2:0]    rx_head_err,  // Head break, framing, parity
    input  wire logic          rx_push,      // Character entered receive FIFO
    input  wire logic [2:0]    rx_push_err,  // Its break, framing, parity
    input  wire logic          rx_overrun,   // Overrun event pulse
    input  wire logic          rx_timeout,   // Stale data event pulse
    input  wire logic [CW-1:0] tx_count,     // Transmit FIFO fill level
    input  wire logic          xoff_det,     // Xoff character received
    input  wire logic          xon_det,      // Xon character received
    input  wire logic          special_det,  // Special character received
    input  wire logic [3:0]    modem_delta,  // Modem input change pulses
    input  wire logic          rts_n,        // Request-to-send pin level
    input  wire logic          cts_n,        // Clear-to-send pin level
    output logic               rx_pop,       // Pop receive FIFO head
    output logic               tx_push,      // Push into transmit FIFO
    output logic      [7:0]    tx_data,      // Character to push
    output logic               irq           // Interrupt output, level
);
    logic [31:0]             prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic [`UIP_IE_W-1:0]    ier_ff;
    logic                    fifo_en_ff;
    logic [CW-1:0]           rx_trig_ff;
    logic [CW-1:0]           tx_trig_ff;
    logic [`UIP_NSRC-1:0]    ists_ff;
    logic [`UIP_NSRC-1:0]    imsk_ff;
    logic                    overrun_ff;
    logic                    timeout_ff;
    logic                    tx_pend_ff;
    logic [3:0]              msr_delta_ff;
    logic                    xoff_char_ff;
    logic                    xoff_spec_ff;
    logic                    flow_ff;
    logic                    rts_q_ff;
    logic                    cts_q_ff;
    logic [CW-1:0]           tx_cnt_q_ff;
    logic                    rx_pop_ff;
    logic                    tx_push_ff;
    logic [7:0]              tx_data_ff;
    logic                    irq_ff;
    logic                    setup;
    logic                    acc;
    logic                    wr;
    logic                    rd;
    logic                    rd_ident;
    logic                    rd_lsr;
    logic                    rd_msr;
    logic                    rd_rhr;
    logic                    wr_thr;
    logic                    rx_nempty;
    logic                    tx_evt;
    logic                    flow_evt;
    logic                    fifo_err;
    logic [7:0]              lsr_val;
    logic [`UIP_NSRC-1:0]    src_pend;
    logic [`UIP_NSRC-1:0]    src_en;
    logic [`UIP_NSRC-1:0]    act;
    logic [5:0]              ident_val;
    uip_pkg::uip_src_t       top_src;
    logic [31:0]             rd_mux;
    logic                    hit;

    uip_err_if err_bus ();
    assign setup     = psel & ~penable;
    assign acc       = psel & penable & pready_ff;
    assign wr        = acc & pwrite;
    assign rd        = acc & ~pwrite;
    assign rd_ident  = rd & (paddr == `UIP_OFF_IDENT);
    assign rd_lsr    = rd & (paddr == `UIP_OFF_LSR);
    assign rd_msr    = rd & (paddr == `UIP_OFF_MSR);
    assign rd_rhr    = rd & (paddr == `UIP_OFF_RHR);
    assign wr_thr    = wr & (paddr == `UIP_OFF_THR);
    assign rx_nempty = (rx_count != '0);

    assign err_bus.push     = rx_push;
    assign err_bus.push_err = |rx_push_err;
    assign err_bus.pop      = rd_rhr & rx_nempty;
    assign err_bus.pop_err  = |rx_head_err;
    assign fifo_err         = err_bus.fifo_err;
    uip_err_track #(
        .DEPTH (DEPTH)
    ) u_err_track (
        .clk  (clk),
        .srst (srst),
        .eb   (err_bus.tracker)
    );

    // Head bits follow the FIFO head and read as zero when empty
    always_comb begin
        lsr_val                 = '0;
        lsr_val[`UIP_LS_DR]     = rx_nempty;
        lsr_val[`UIP_LS_OE]     = overrun_ff;
        lsr_val[`UIP_LS_HEAD +: 3] = rx_nempty ? rx_head_err : 3'h0;
        lsr_val[`UIP_LS_THE]    = (tx_count == '0);
        lsr_val[`UIP_LS_FERR]   = fifo_err;
    end

    // Transmit crossing: fill level falls to the trigger with FIFO enabled, or FIFO drains with it disabled
    assign tx_evt   = fifo_en_ff ? ((tx_count <= tx_trig_ff) && (tx_cnt_q_ff > tx_trig_ff))
                                 : ((tx_count == '0) && (tx_cnt_q_ff != '0));
    assign flow_evt = (rts_n & ~rts_q_ff) | (cts_n & ~cts_q_ff);

    always_comb begin
        src_pend[`UIP_S_LS]   = overrun_ff | fifo_err;
        src_pend[`UIP_S_TO]   = timeout_ff;
        src_pend[`UIP_S_RXD]  = fifo_en_ff ? (rx_count > rx_trig_ff) : rx_nempty;
        src_pend[`UIP_S_TX]   = tx_pend_ff;
        src_pend[`UIP_S_MS]   = |msr_delta_ff;
        src_pend[`UIP_S_XOFF] = xoff_char_ff | xoff_spec_ff;
        src_pend[`UIP_S_FLOW] = flow_ff;
        // Bit order follows the source index, flow pin down to line status
        src_en = {ier_ff[`UIP_IE_FLOW], ier_ff[`UIP_IE_XOFF], ier_ff[`UIP_IE_MS], ier_ff[`UIP_IE_TX],
                  ier_ff[`UIP_IE_RX], ier_ff[`UIP_IE_RX], ier_ff[`UIP_IE_LS]};
    end

    assign act = src_pend & src_en;

    // Scan from the lowest rank so the highest pending source wins
    always_comb begin
        top_src = uip_pkg::SRC_NONE;
        for (int i = `UIP_NSRC - 1; i >= 0; i--) begin
            if (act[i]) begin
                top_src = uip_pkg::uip_src_t'(3'(i + 1));
            end
        end
    end

    // Ident codes indexed by source, in enum order
    localparam logic [5:0] ID_TAB [8] = '{`UIP_ID_NONE, `UIP_ID_LS, `UIP_ID_TO, `UIP_ID_RXD,
        `UIP_ID_TX, `UIP_ID_MS, `UIP_ID_XOFF, `UIP_ID_FLOW};
    assign ident_val = ID_TAB[top_src];

    always_comb begin
        rd_mux = '0;
        hit    = 1'b1;
        case (paddr)
            `UIP_OFF_IER:   rd_mux[`UIP_IE_W-1:0] = ier_ff;
            `UIP_OFF_IDENT: rd_mux[5:0] = ident_val;
            `UIP_OFF_LSR:   rd_mux[7:0] = lsr_val;
            `UIP_OFF_MSR:   rd_mux[3:0] = msr_delta_ff;
            `UIP_OFF_RHR:   rd_mux[7:0] = rx_head_data;
            `UIP_OFF_THR:   rd_mux = '0;
            `UIP_OFF_FCTL: begin
                rd_mux[`UIP_FC_EN]       = fifo_en_ff;
                rd_mux[`UIP_FC_RXT +: CW] = rx_trig_ff;
                rd_mux[`UIP_FC_TXT +: CW] = tx_trig_ff;
            end
            `UIP_OFF_ISTS:  rd_mux[`UIP_NSRC-1:0] = ists_ff;
            `UIP_OFF_IMSK:  rd_mux[`UIP_NSRC-1:0] = imsk_ff;
            default:        hit = 1'b0;
        endcase
    end

    // Bus slave: one wait-free access phase, data latched at setup
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~hit;
            if (setup) begin
                prdata_ff <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ier_ff     <= '0;
            fifo_en_ff <= 1'b0;
            rx_trig_ff <= CW'(`UIP_TRIG_RST);
            tx_trig_ff <= CW'(`UIP_TRIG_RST);
            imsk_ff    <= '0;
        end else if (wr) begin
            if (paddr == `UIP_OFF_IER) begin
                ier_ff <= pwdata[`UIP_IE_W-1:0];
            end
            if (paddr == `UIP_OFF_FCTL) begin
                fifo_en_ff <= pwdata[`UIP_FC_EN];
                rx_trig_ff <= pwdata[`UIP_FC_RXT +: CW];
                tx_trig_ff <= pwdata[`UIP_FC_TXT +: CW];
            end
            if (paddr == `UIP_OFF_IMSK) begin
                imsk_ff <= pwdata[`UIP_NSRC-1:0];
            end
        end
    end

    // Source latches: a new event always wins over its clear
    always_ff @(posedge clk) begin
        if (srst) begin
            overrun_ff   <= 1'b0;
            timeout_ff   <= 1'b0;
            tx_pend_ff   <= 1'b0;
            msr_delta_ff <= '0;
            xoff_char_ff <= 1'b0;
            xoff_spec_ff <= 1'b0;
            flow_ff      <= 1'b0;
            rts_q_ff     <= 1'b1;
            cts_q_ff     <= 1'b1;
            tx_cnt_q_ff  <= '0;
        end else begin
            overrun_ff   <= rx_overrun | (overrun_ff & ~rd_lsr);
            timeout_ff   <= rx_timeout | (timeout_ff & ~rd_rhr);
            tx_pend_ff   <= tx_evt | (tx_pend_ff & ~(rd_ident | wr_thr));
            msr_delta_ff <= modem_delta | (msr_delta_ff & ~{4{rd_msr}});
            xoff_char_ff <= xoff_det | (xoff_char_ff & ~xon_det);
            xoff_spec_ff <= special_det | (xoff_spec_ff & ~rd_lsr);
            flow_ff      <= flow_evt | (flow_ff & ~rd_ident);
            rts_q_ff     <= rts_n;
            cts_q_ff     <= cts_n;
            tx_cnt_q_ff  <= tx_count;
        end
    end

    // Sticky status with write-one-to-clear; a still active source re-sets
    always_ff @(posedge clk) begin
        if (srst) begin
            ists_ff <= '0;
            irq_ff  <= 1'b0;
        end else begin
            if (wr && (paddr == `UIP_OFF_ISTS)) begin
                ists_ff <= (ists_ff & ~pwdata[`UIP_NSRC-1:0]) | act;
            end else begin
                ists_ff <= ists_ff | act;
            end
            irq_ff <= |(ists_ff & imsk_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_pop_ff  <= 1'b0;
            tx_push_ff <= 1'b0;
            tx_data_ff <= '0;
        end else begin
            rx_pop_ff  <= rd_rhr & rx_nempty;
            tx_push_ff <= wr_thr;
            if (wr_thr) begin
                tx_data_ff <= pwdata[7:0];
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign rx_pop  = rx_pop_ff;
    assign tx_push = tx_push_ff;
    assign tx_data = tx_data_ff;
    assign irq     = irq_ff;

    ident_flag_a: assert property (@(posedge clk) disable iff (srst)
        (ident_val[0] == 1'b0) == (|act))
        else $error("ident pending flag disagrees with enabled sources");
    ls_first_a: assert property (@(posedge clk) disable iff (srst)
        act[`UIP_S_LS] |-> ident_val == `UIP_ID_LS)
        else $error("line status not reported first");
    ls_source_a: assert property (@(posedge clk) disable iff (srst)
        fifo_err |-> src_pend[`UIP_S_LS])
        else $error("aggregate error flag did not raise line status");
    oe_clear_a: assert property (@(posedge clk) disable iff (srst)
        rd_lsr && !rx_overrun |=> !overrun_ff)
        else $error("overrun not cleared by status read");
    to_clear_a: assert property (@(posedge clk) disable iff (srst)
        rd_rhr && !rx_timeout |=> !timeout_ff)
        else $error("time-out not cleared by holding read");
    tx_clear_a: assert property (@(posedge clk) disable iff (srst)
        (rd_ident || wr_thr) && !tx_evt |=> !tx_pend_ff)
        else $error("transmit interrupt not cleared");
    tx_raise_a: assert property (@(posedge clk) disable iff (srst)
        tx_evt |=> tx_pend_ff)
        else $error("transmit event lost");
    xon_clear_a: assert property (@(posedge clk) disable iff (srst)
        xon_det && !xoff_det |=> !xoff_char_ff)
        else $error("Xon did not clear Xoff interrupt");
    spec_clear_a: assert property (@(posedge clk) disable iff (srst)
        rd_lsr && !special_det |=> !xoff_spec_ff)
        else $error("special character interrupt not cleared");
    flow_raise_a: assert property (@(posedge clk) disable iff (srst)
        $rose(rts_n) |=> flow_ff)
        else $error("flow pin rise not captured");
    msr_clear_a: assert property (@(posedge clk) disable iff (srst)
        rd_msr && modem_delta == 4'h0 |=> !src_pend[`UIP_S_MS])
        else $error("modem status not cleared by read");
    head_zero_a: assert property (@(posedge clk) disable iff (srst)
        !rx_nempty |-> lsr_val[`UIP_LS_HEAD +: 3] == 3'h0)
        else $error("head bits nonzero with empty FIFO");
    rxd_level_a: assert property (@(posedge clk) disable iff (srst)
        fifo_en_ff && ier_ff[`UIP_IE_RX] && rx_count > rx_trig_ff |=> ists_ff[`UIP_S_RXD])
        else $error("receive data over trigger not flagged");
    irq_follow_a: assert property (@(posedge clk) disable iff (srst)
        act[`UIP_S_LS] && imsk_ff[`UIP_S_LS] |=> ##1 irq)
        else $error("interrupt output missing for unmasked source");
endmodule
`default_nettype wire

// File: verif/uip_rxq_model.sv
// Receive FIFO model feeding head character and push events to the design
`timescale 1ns/1ps
`default_nettype none
module uip_rxq_model (
    input  wire logic       clk,          // Device clock
    input  wire logic       req,          // Bench asks for a push
    input  wire logic [7:0] req_data,     // Character to push
    input  wire logic [2:0] req_err,      // Its break, framing, parity
    input  wire logic       rx_pop,       // Head pop from the design
    output logic      [6:0] rx_count,     // Fill level
    output logic      [7:0] rx_head_data, // Head character
    output logic      [2:0] rx_head_err,  // Head error bits
    output logic            rx_push,      // Push pulse
    output logic      [2:0] rx_push_err   // Error bits of pushed character
);
    logic [10:0] q[$];
    logic [10:0] last;
    initial begin
        {rx_count, rx_head_data, rx_head_err, rx_push, rx_push_err} = 22'h0;
        last = 11'h0;
    end
    // Empty FIFO shows garbage on the head lines, the design must hide it
    always @(posedge clk) begin
        if (rx_pop === 1'b1 && q.size() > 0) begin
            last = q.pop_front();
        end
        if (req) begin
            q.push_back({req_err, req_data});
        end
        rx_push <= req;
        rx_push_err <= req_err;
        rx_count <= 7'(q.size());
        rx_head_data <= q.size() > 0 ? q[0][7:0] : ~last[7:0];
        rx_head_err <= q.size() > 0 ? q[0][10:8] : 3'h7;
    end
endmodule
`default_nettype wire

// File: verif/uip_top_tb_top.sv
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/1ps
`default_nettype none
`include "uip_map.svh"
module uip_top_tb_top;
    logic        clk, srst, psel, penable, pwrite, req, rts_n, cts_n, ov, xsp, fen;
    logic        pready, pslverr, perr, rx_pop, tx_push, irq, rx_push;
    logic [2:0]  req_err, rx_head_err, rx_push_err;
    logic [6:0]  rx_count, tx_count;
    logic [7:0]  paddr, req_data, rx_head_data, tx_data, tx_seen, td;
    logic [8:0]  evv;
    logic [31:0] pwdata, prdata, rv;
    logic [10:0] mq[$];
    int          miscompares, tests_run, cyc, seed, pend[7];

    uip_top i_uip_top (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_count(rx_count), .rx_head_data(rx_head_data),
        .rx_head_err(rx_head_err), .rx_push(rx_push), .rx_push_err(rx_push_err),
        .rx_overrun(evv[4]), .rx_timeout(evv[3]), .tx_count(tx_count),
        .xoff_det(evv[2]), .xon_det(evv[1]), .special_det(evv[0]),
        .modem_delta(evv[8:5]), .rts_n(rts_n), .cts_n(cts_n), .rx_pop(rx_pop),
        .tx_push(tx_push), .tx_data(tx_data), .irq(irq));
    uip_rxq_model i_uip_rxq_model (
        .clk(clk), .req(req), .req_data(req_data), .req_err(req_err), .rx_pop(rx_pop),
        .rx_count(rx_count), .rx_head_data(rx_head_data), .rx_head_err(rx_head_err),
        .rx_push(rx_push), .rx_push_err(rx_push_err));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tx_push === 1'b1) tx_seen <= tx_data;
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end

    function automatic logic any_err();
        logic e = 1'b0;
        foreach (mq[i]) e |= |mq[i][10:8];
        return e;
    endfunction
    // Reference ident: first pending source in rank order
    function automatic logic [31:0] exp_id();
        int p[7] = pend;
        int c[7] = '{6, 12, 4, 2, 0, 16, 32};
        p[0] |= ov | any_err();
        p[2] = fen ? mq.size() > 8 : mq.size() > 0;
        for (int i = 0; i < 7; i++) if (p[i] != 0) return c[i];
        return 1;
    endfunction
    function automatic logic [31:0] exp_lsr();
        logic [31:0] v = {24'h0, any_err(), 1'b0, tx_count == 7'h0, 3'h0, ov, mq.size() > 0};
        if (mq.size() > 0) v[4:2] = mq[0][10:8];
        return v;
    endfunction

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, rv, e);
    endtask
    task automatic rd_id();
        rd(`UIP_OFF_IDENT, exp_id(), "ident");
        pend[3] = 0;
        pend[6] = 0;
    endtask
    task automatic rd_lsr();
        rd(`UIP_OFF_LSR, exp_lsr(), "lsr");
        ov = 1'b0;
        if (xsp) pend[5] = 0;
        xsp = 1'b0;
    endtask
    task automatic rd_rhr();
        rd(`UIP_OFF_RHR, {24'h0, mq[0][7:0]}, "rhr");
        void'(mq.pop_front());
        pend[1] = 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic push(input logic [2:0] e);
        logic [7:0] d = 8'($random(seed));
        @(posedge clk);
        req <= 1'b1;
        req_data <= d;
        req_err <= e;
        mq.push_back({e, d});
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic ev(input logic [8:0] m, input int s);
        if (s >= 0) pend[s] = 1;
        @(posedge clk);
        evv <= m;
        @(posedge clk);
        evv <= 9'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic txev();
        @(posedge clk);
        tx_count <= 7'h3;
        @(posedge clk);
        tx_count <= 7'h0;
        pend[3] = 1;
        repeat (3) @(posedge clk);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        {srst, psel, penable, pwrite, req, rts_n, cts_n, ov, xsp, fen} = 10'b1000011000;
        {paddr, pwdata, req_data, req_err, evv, tx_count} = 67'h0;
        seed = 32'hcfc3b6b7;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(`UIP_OFF_IER, 32'h0, "ier");
        rd_id();
        rd_lsr();
        chk("irq", irq, 1'b0);
        rd(8'h24, 32'h0, "unmapped");
        chk("slverr", perr, 1'b1);
        $display("test reset done");
        wr(`UIP_OFF_IER, 32'h3f);
        wr(`UIP_OFF_IMSK, 32'h7f);
        push(3'h2);
        push(3'h0);
        push(3'h1);
        rd_lsr();
        rd_id();
        chk("irq", irq, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rd_rhr();
            rd_lsr();
            rd_id();
        end
        wr(`UIP_OFF_ISTS, 32'h7f);
        $display("test errors done");
        txev();
        ev(9'h0a0, 4);
        ov = 1'b1;
        ev(9'h010, -1);
        rd_id();
        rd_lsr();
        rd_id();
        rd(`UIP_OFF_MSR, 32'h5, "msr");
        pend[4] = 0;
        rd_id();
        for (int i = 0; i < 2; i++) begin
            txev();
            td = 8'($random(seed));
            if (i == 0) rd_id();
            else begin
                wr(`UIP_OFF_THR, {24'h0, td});
                pend[3] = 0;
            end
            rd_id();
        end
        chk("tx_data", tx_seen, td);
        $display("test priority done");
        ev(9'h004, 5);
        rd_id();
        pend[5] = 0;
        ev(9'h002, -1);
        rd_id();
        xsp = 1'b1;
        ev(9'h001, 5);
        rd_id();
        rd_lsr();
        rd_id();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            {rts_n, cts_n} <= (i == 0) ? 2'b10 : 2'b01;
            @(posedge clk);
            {rts_n, cts_n} <= 2'b11;
            pend[6] = 1;
            repeat (3) @(posedge clk);
            rd_id();
            rd_id();
        end
        $display("test flow done");
        wr(`UIP_OFF_FCTL, 32'h0008_0801);
        fen = 1'b1;
        push(3'h0);
        ev(9'h008, 1);
        rd_id();
        rd_rhr();
        rd_id();
        repeat (9) push(3'h0);
        rd_id();
        repeat (9) rd_rhr();
        rd_id();
        $display("test fifo done");
        wr(`UIP_OFF_FCTL, 32'h0);
        fen = 1'b0;
        wr(`UIP_OFF_ISTS, 32'h7f);
        wr(`UIP_OFF_IMSK, 32'h0);
        ev(9'h020, 4);
        chk("irq", irq, 1'b0);
        rd(`UIP_OFF_ISTS, 32'h10, "ists");
        wr(`UIP_OFF_IMSK, 32'h10);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b1);
        rd(`UIP_OFF_MSR, 32'h1, "msr");
        pend[4] = 0;
        wr(`UIP_OFF_ISTS, 32'h10);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b0);
        wr(`UIP_OFF_IER, 32'h0);
        wr(`UIP_OFF_IMSK, 32'h7f);
        push(3'h0);
        chk("irq", irq, 1'b0);
        rd(`UIP_OFF_ISTS, 32'h0, "ists");
        rd_lsr();
        rd_rhr();
        $display("test irq done");
        close_out();
    end
endmodule
`default_nettype wire
